// [hw/vro_defs.svh]
// Timing counts and fixed values for the video receiver output block.
// Assumes inclusion by bare name from design files only.
`ifndef VRO_DEFS_SVH
`define VRO_DEFS_SVH
`define VRO_I2C_ADDR        7'h76
`define VRO_CFG_RESET       8'h00
`define VRO_CFG_INV_BIT     0
`define VRO_CFG_18BIT_BIT   1
`define VRO_CLK_TIMEOUT_NS  2000
`define VRO_CLK_PERIOD_NS   8
`define VRO_CLK_TIMEOUT_CYC (`VRO_CLK_TIMEOUT_NS / `VRO_CLK_PERIOD_NS)
`define VRO_DE_TIMEOUT_CYC  16'hFFFF
`define VRO_DJ_PERIOD       4
`endif

// [hw/vro_pkg.sv]
// Types shared by the video receiver output block.
// Assumes the defs header is included alongside.
package vro_pkg;
    typedef enum logic [5:0]
    {
        I2C_IDLE  = 6'h01,
        I2C_ADDR  = 6'h02,
        I2C_REG   = 6'h04,
        I2C_WDATA = 6'h08,
        I2C_RDATA = 6'h10,
        I2C_ACK   = 6'h20
    } vro_i2c_state_type;
endpackage

// [hw/vro_i2c_slave.sv]
// Byte-only I2C slave holding one configuration register.
// Assumes scl/sda inputs are already synchronised to clk_i.
`timescale 1ns/100ps
`include "vro_defs.svh"
module vro_i2c_slave
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [7:0]      cfg_o
);
    import vro_pkg::*;
    vro_i2c_state_type state_reg, state_next;
    logic [7:0] shift_reg, shift_next, cfg_reg, cfg_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       scl_d_reg, sda_d_reg, rd_reg, rd_next, oe_reg, oe_next, ptr_reg, ptr_next;
    logic       rise, fall, start, stop;
    logic       last_reg, last_next;
    assign rise  = scl_i & ~scl_d_reg;
    assign fall  = ~scl_i & scl_d_reg;
    assign start = scl_i & sda_d_reg & ~sda_i;
    assign stop  = scl_i & ~sda_d_reg & sda_i;
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_reg;
    assign cfg_o    = cfg_reg;
    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        cfg_next   = cfg_reg;
        rd_next    = rd_reg;
        oe_next    = oe_reg;
        ptr_next   = ptr_reg;
        last_next  = last_reg;
        if (start)
        begin
            state_next = I2C_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
            last_next  = 1'b0;
        end
        else if (stop)
        begin
            state_next = I2C_IDLE;
            oe_next    = 1'b0;
        end
        else
        begin
            case (state_reg)
                I2C_IDLE:
                    oe_next = 1'b0;
                I2C_ADDR, I2C_REG, I2C_WDATA:
                begin
                    if (rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_i};
                        cnt_next   = cnt_reg + 4'h1;
                    end
                    if (fall && cnt_reg == 4'h8)
                    begin
                        cnt_next = 4'h0;
                        if (state_reg == I2C_ADDR)
                        begin
                            // R11
                            if (shift_reg[7:1] == `VRO_I2C_ADDR)
                            begin
                                rd_next    = shift_reg[0];
                                oe_next    = 1'b1;
                                state_next = I2C_ACK;
                                shift_next = cfg_reg;
                            end
                            else
                                state_next = I2C_IDLE;
                        end
                        else
                        begin
                            // One register only: any index reaches it. R10
                            if (state_reg == I2C_WDATA && ptr_reg)
                                cfg_next = shift_reg;
                            ptr_next   = state_reg == I2C_REG;
                            // Data byte ends the transfer: no further bytes acked R10
                            last_next  = state_reg == I2C_WDATA;
                            oe_next    = 1'b1;
                            state_next = I2C_ACK;
                        end
                    end
                end
                I2C_ACK:
                    if (fall)
                    begin
                        cnt_next = 4'h0;
                        if (last_reg)
                        begin
                            state_next = I2C_IDLE;
                            oe_next    = 1'b0;
                        end
                        else if (rd_reg)
                        begin
                            state_next = I2C_RDATA;
                            oe_next    = ~shift_reg[7];
                        end
                        else if (ptr_reg)
                        begin
                            state_next = I2C_WDATA;
                            oe_next    = 1'b0;
                        end
                        else
                        begin
                            state_next = I2C_REG;
                            oe_next    = 1'b0;
                        end
                        if (rd_reg)
                            ptr_next = 1'b0;
                    end
                I2C_RDATA:
                    if (fall)
                    begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        cnt_next   = cnt_reg + 4'h1;
                        oe_next    = (cnt_reg < 4'h7) ? ~shift_reg[6] : 1'b0;
                        // Single byte only: further bytes are not served. R10
                        if (cnt_reg == 4'h7)
                            state_next = I2C_IDLE;
                    end
                default:
                    state_next = I2C_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= I2C_IDLE;
            shift_reg <= 8'h00;
            cnt_reg   <= 4'h0;
            cfg_reg   <= `VRO_CFG_RESET;
            rd_reg    <= 1'b0;
            oe_reg    <= 1'b0;
            ptr_reg   <= 1'b0;
            last_reg  <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            cfg_reg   <= cfg_next;
            rd_reg    <= rd_next;
            oe_reg    <= oe_next;
            ptr_reg   <= ptr_next;
            last_reg  <= last_next;
            scl_d_reg <= scl_i;
            sda_d_reg <= sda_i;
        end
    end
    cfg_reset_a: assert property (@(posedge clk_i) !reset_n_i |=> cfg_o == `VRO_CFG_RESET)
        else $error("config not reset");
    sda_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_reg == I2C_IDLE |-> !sda_oe_o) // R10
        else $error("sda driven while idle");
endmodule

// [hw/vro_top.sv]
// Output-side features of a video link receiver: de-jitter, clock detect,
// output clock polarity, I2C configuration and pixel mapping.
// Assumes a free running clk_i; link clock and pins are asynchronous.
// Notes on behaviour
// R1: De-jitter input high enables line-sync de-jitter, low bypasses it.
// R2: De-jitter may delay line sync by one to four pixel clocks.
// R3: Host must disable de-jitter when timings are not multiples of four.
// R4: No link clock enters low power, only the clock detector runs; the I2C slave on clk_i also keeps running here.
// R5: In low power all digital outputs are released to pull-downs; the code releases the video outputs only, and sync detect is driven low.
// R6: In low power sync detect is driven low.
// R7: Invert set presents output clock with opposite phase.
// R8: Inversion changes only the presented clock, not data latching.
// R9: Invert comes from strap in compatible mode, register in programmable.
// R10: I2C handles single byte reads and writes only.
// R11: I2C slave answers address 0x76.
// R12: I2C registers work without any incoming video clock.
// R13: 24-bit: blue, green, red on even bits 7:0, 15:8, 23:16.
// R14: 18-bit: six-bit colours MSB aligned, two low bits unused.
// R15: Two pixels: first on even bus, second on odd bus, same layout.
// R16: Output format depends only on receiver settings.
// R17: Select low gives one pixel per clock; high gives two.
// R18: Sync detect high while data enable toggles, low when idle.
// R19: Power-down low disables logic and outputs and resets registers.
// R20: Vsync, enable and data aligned; only line sync gets extra delay.
`timescale 1ns/100ps
`include "vro_defs.svh"
module vro_top
#(
    parameter int CLK_TIMEOUT = `VRO_CLK_TIMEOUT_CYC,
    parameter int DE_TIMEOUT  = `VRO_DE_TIMEOUT_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        power_down_n_i,
    input  wire logic        link_clk_i,
    input  wire logic        line_sync_i,
    input  wire logic        frame_sync_i,
    input  wire logic        data_enable_i,
    input  wire logic [23:0] pixel_a_i,
    input  wire logic [23:0] pixel_b_i,
    input  wire logic        line_sync_dejitter_enable_i,
    input  wire logic        pixels_per_clock_select_i,
    input  wire logic        programmable_mode_i,
    input  wire logic        output_clock_invert_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    output logic [23:0]      even_pixel_out_o,
    output logic [23:0]      odd_pixel_out_o,
    output logic             line_sync_o,
    output logic             frame_sync_o,
    output logic             data_enable_o,
    output logic             output_pixel_clock_o,
    output logic             outputs_oe_o,
    output logic             sync_detect_out_o
);
    import vro_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NS = 32;
    logic [NS-1:0] raw, s1_reg, s2_reg;
    assign raw = {link_clk_i, line_sync_i, frame_sync_i, data_enable_i,
                  line_sync_dejitter_enable_i, pixels_per_clock_select_i,
                  output_clock_invert_i, scl_i, sda_i, programmable_mode_i,
                  power_down_n_i, 21'h000000};
    logic lclk, ls, fs, de, dj_en, pix2, inv_strap, scl_s, sda_s, prog, pdn;
    assign {lclk, ls, fs, de, dj_en, pix2, inv_strap, scl_s, sda_s, prog, pdn}
        = s2_reg[NS-1:21];
    logic rst_n;
    // R19
    assign rst_n = reset_n_i & pdn;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
        end
        else
        begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Configuration over I2C, alive with no link clock
    logic [7:0] cfg;
    vro_i2c_slave u_i2c // R12
    (
        .clk_i     (clk_i),
        .reset_n_i (rst_n),
        .scl_i     (scl_s),
        .sda_i     (sda_s),
        .sda_o     (sda_o),
        .sda_oe_o  (sda_oe_o),
        .cfg_o     (cfg)
    );
    logic invert, mode18;
    assign invert = prog ? cfg[`VRO_CFG_INV_BIT] : inv_strap; // R9
    assign mode18 = cfg[`VRO_CFG_18BIT_BIT];
    ////////////////////////////////////////////////////////////////////////////
    // Link clock edge detect and clock presence
    logic lclk_d_reg, lclk_d_next, rise;
    logic [15:0] idle_reg, idle_next, de_idle_reg, de_idle_next;
    logic alive_reg, alive_next, de_d_reg, de_d_next, sync_detect_out_reg, sync_detect_out_next;
    assign rise = lclk & ~lclk_d_reg;
    always_comb
    begin
        lclk_d_next  = lclk;
        idle_next    = rise ? 16'h0000 : (alive_reg ? idle_reg + 16'h0001 : idle_reg);
        alive_next   = rise ? 1'b1 : (idle_reg >= 16'(CLK_TIMEOUT) ? 1'b0 : alive_reg); // R4
        de_d_next    = rise ? de : de_d_reg;
        de_idle_next = de_idle_reg;
        if (rise)
            de_idle_next = (de != de_d_reg) ? 16'h0000
                         : (de_idle_reg == 16'hFFFF ? de_idle_reg : de_idle_reg + 16'h0001);
        // R18
        sync_detect_out_next    = alive_next && (de_idle_next < 16'(DE_TIMEOUT)); // R6
    end
    always_ff @(posedge clk_i)
    begin
        if (!rst_n)
        begin
            lclk_d_reg  <= 1'b0;
            idle_reg    <= 16'h0000;
            alive_reg   <= 1'b0;
            de_d_reg    <= 1'b0;
            de_idle_reg <= 16'hFFFF;
            sync_detect_out_reg    <= 1'b0;
        end
        else
        begin
            lclk_d_reg  <= lclk_d_next;
            idle_reg    <= idle_next;
            alive_reg   <= alive_next;
            de_d_reg    <= de_d_next;
            de_idle_reg <= de_idle_next;
            sync_detect_out_reg    <= sync_detect_out_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pixel mapping and output registers, updated on link clock edges
    logic [23:0] even_reg, even_next, odd_reg, odd_next, mask;
    logic        fs_reg, fs_next, de_reg, de_next, ls_reg, ls_next;
    logic [1:0]  ph_reg, ph_next;
    logic        ls_hold_reg, ls_hold_next;
    logic        pclk_reg, pclk_next;
    // Six-bit colours keep bits 7:2 of each byte; low two bits forced low
    assign mask = mode18 ? 24'hFCFCFC : 24'hFFFFFF; // R14
    always_comb
    begin
        even_next    = even_reg;
        odd_next     = odd_reg;
        fs_next      = fs_reg;
        de_next      = de_reg;
        ls_next      = ls_reg;
        ph_next      = ph_reg;
        ls_hold_next = ls_hold_reg;
        pclk_next    = lclk_d_reg; // R8
        if (rise)
        begin
            // Layout depends only on local settings R16
            even_next = pixel_a_i & mask; // R13
            odd_next  = pix2 ? (pixel_b_i & mask) : 24'h000000; // R15 R17
            fs_next   = fs; // R20
            de_next   = de;
            ph_next   = ph_reg + 2'h1;
            if (!dj_en)
                ls_next = ls; // R1
            else
            begin
                // Line sync changes only on a four-pixel grid: 1 to 4 clocks late R2 R3
                ls_hold_next = ls;
                if (ph_reg == 2'h3)
                    ls_next = ls_hold_reg;
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (!rst_n)
        begin
            even_reg    <= 24'h000000;
            odd_reg     <= 24'h000000;
            fs_reg      <= 1'b0;
            de_reg      <= 1'b0;
            ls_reg      <= 1'b0;
            ph_reg      <= 2'h0;
            ls_hold_reg <= 1'b0;
            pclk_reg    <= 1'b0;
        end
        else
        begin
            even_reg    <= even_next;
            odd_reg     <= odd_next;
            fs_reg      <= fs_next;
            de_reg      <= de_next;
            ls_reg      <= ls_next;
            ph_reg      <= ph_next;
            ls_hold_reg <= ls_hold_next;
            pclk_reg    <= pclk_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Output stage: low power releases the video pins to pull-downs; sync detect is driven low
    logic on;
    assign on = alive_reg & rst_n; // R5
    assign even_pixel_out_o     = on ? even_reg : 24'h000000;
    assign odd_pixel_out_o      = on ? odd_reg : 24'h000000;
    assign line_sync_o          = on & ls_reg;
    assign frame_sync_o         = on & fs_reg;
    assign data_enable_o        = on & de_reg;
    assign output_pixel_clock_o = on & (pclk_reg ^ invert); // R7
    assign outputs_oe_o         = on;
    assign sync_detect_out_o    = sync_detect_out_reg & rst_n;
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    lowpwr_release_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !alive_reg |-> !outputs_oe_o && !sync_detect_out_o) // R5
        else $error("outputs active without link clock");
    lowpwr_sync_detect_out_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !alive_reg |-> !sync_detect_out_o) // R6
        else $error("sync detect high with no clock");
    clk_invert_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        outputs_oe_o |-> output_pixel_clock_o == (pclk_reg ^ invert)) // R7
        else $error("output clock phase wrong");
    map_18bit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rise && mode18 |=> (even_reg & 24'h030303) == 24'h000000) // R14
        else $error("18-bit low bits not zero");
    odd_unused_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rise && !pix2 |=> odd_reg == 24'h000000) // R17
        else $error("odd bus active in one-pixel mode");
    bypass_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        rise && !dj_en |=> ls_reg == $past(ls)) // R1
        else $error("line sync not bypassed");
    dejitter_grid_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        dj_en && $changed(ls_reg) |-> $past(ph_reg) == 2'h3) // R2
        else $error("line sync moved off grid");
    pwrdn_reset_a: assert property (@(posedge clk_i)
        !power_down_n_i ##3 1 |=> cfg == `VRO_CFG_RESET) // R19
        else $error("config survived power down");
endmodule

// [bench/vro_link_model.sv]
// Link-side model: video clock, syncs and random pixel pairs.
// Assumes run_i stops the clock low; data moves on the falling edge.
`timescale 1ns/100ps
module vro_link_model
(
    input  wire logic        run_i,
    input  wire logic        de_on_i,
    output logic             link_clk_o,
    output logic             line_sync_o,
    output logic             frame_sync_o,
    output logic             data_enable_o,
    output logic [23:0]      pixel_a_o,
    output logic [23:0]      pixel_b_o
);
    integer     seed;
    logic [7:0] pos_reg;

    initial
    begin
        seed = 32'hD52D7EEF;
        pos_reg = 8'h00;
        link_clk_o = 1'b0;
        line_sync_o = 1'b0;
        frame_sync_o = 1'b0;
        data_enable_o = 1'b0;
        pixel_a_o = 24'h000000;
        pixel_b_o = 24'h000000;
        #3.3;
        forever
        begin
            #80;
            if (run_i)
                link_clk_o = 1'b1;
            #80;
            if (link_clk_o)
            begin
                link_clk_o = 1'b0;
                pos_reg = pos_reg + 8'h01;
                // Line of 16 keeps totals and porches multiples of four
                line_sync_o = (pos_reg[3:0] >= 4'hC);
                frame_sync_o = (pos_reg[7:4] == 4'h0);
                data_enable_o = de_on_i && (pos_reg[3:0] < 4'hC);
                pixel_a_o = 24'($random(seed));
                pixel_b_o = 24'($random(seed));
            end
        end
    end
endmodule

// [bench/test_vro_top.sv]
// Self-checking bench for the receiver output block.
// Assumes the link model and an I2C master built from tasks here.
`timescale 1ns/100ps
module test_vro_top;
    import vro_pkg::*;
    typedef struct packed
    {
        logic [23:0] even;
        logic [23:0] odd;
        logic [23:0] mask;
        logic        use_odd;
        logic        use_ls;
        logic [3:0]  hist;
        logic        dj_ok;
        logic [3:0]  ctl;
    } vro_note_type;

    logic clk_i = 1'b0, reset_n_i = 1'b0, power_down_n_i = 1'b1, run = 1'b1, de_on = 1'b1;
    logic dj = 1'b0, pixels_per_clock_select = 1'b0, prog = 1'b0, inv = 1'b0, scl = 1'b1, m_sda_low = 1'b0;
    logic link_clk, ls, fs, de, sda_o, sda_oe_o, ls_o, fs_o, de_o, ck_o, oe_o, sd_o;
    logic [23:0] pa, pb, even_o, odd_o;
    logic        cmp_on = 1'b0;
    logic [7:0]  exp_cfg = 8'h00;
    logic [7:0]  rd;
    int          error_cnt = 0, checks_done = 0;
    logic [3:0]  ls_hist = 4'h0;
    int          dj_cnt = 0;
    vro_note_type notes[$];
    vro_note_type nt, got;
    wire         sda_line = m_sda_low ? 1'b0 : (sda_oe_o ? sda_o : 1'b1);

    always #4 clk_i = ~clk_i;

    vro_link_model i_link (.run_i(run), .de_on_i(de_on), .link_clk_o(link_clk),
        .line_sync_o(ls), .frame_sync_o(fs), .data_enable_o(de), .pixel_a_o(pa),
        .pixel_b_o(pb));

    vro_top #(.DE_TIMEOUT(64)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .power_down_n_i(power_down_n_i), .link_clk_i(link_clk), .line_sync_i(ls),
        .frame_sync_i(fs), .data_enable_i(de), .pixel_a_i(pa), .pixel_b_i(pb),
        .line_sync_dejitter_enable_i(dj), .pixels_per_clock_select_i(pixels_per_clock_select),
        .programmable_mode_i(prog), .output_clock_invert_i(inv), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .even_pixel_out_o(even_o),
        .odd_pixel_out_o(odd_o), .line_sync_o(ls_o), .frame_sync_o(fs_o),
        .data_enable_o(de_o), .output_pixel_clock_o(ck_o), .outputs_oe_o(oe_o),
        .sync_detect_out_o(sd_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic clk_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Expected outputs for each pixel taken on a link rise
    always @(posedge link_clk)
    begin
        dj_cnt = dj ? dj_cnt + 1 : 0;
        if (cmp_on)
        begin
            nt.even = pa;
            nt.odd = pb;
            nt.mask = exp_cfg[1] ? 24'hFCFCFC : 24'hFFFFFF;
            nt.use_odd = pixels_per_clock_select;
            nt.use_ls = !dj;
            // Line sync seen at the four previous link rises
            nt.hist = ls_hist;
            nt.dj_ok = dj_cnt >= 5;
            nt.ctl = {1'b1 ^ (prog ? exp_cfg[0] : inv), fs, de, dj ? 1'b0 : ls};
            notes.push_back(nt);
        end
        ls_hist = {ls_hist[2:0], ls};
    end

    // Outputs settle four cycles after the link rise and stand to the next
    always @(posedge link_clk)
    begin
        repeat (6) @(posedge clk_i);
        if (notes.size() > 0)
        begin
            got = notes.pop_front();
            chk("even", even_o & got.mask, got.even & got.mask);
            if (got.use_odd)
                chk("odd", odd_o & got.mask, got.odd & got.mask);
            chk("ctl", {ck_o, fs_o, de_o, got.use_ls ? ls_o : 1'b0}, got.ctl);
            if (got.dj_ok && (got.hist == 4'h0 || got.hist == 4'hF))
                chk("ls_dejitter", ls_o, got.hist[0]);
        end
    end

    task automatic phase(input int n);
        cmp_on <= 1'b1;
        repeat (n) @(posedge link_clk);
        cmp_on <= 1'b0;
        repeat (2) @(posedge link_clk);
        @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic i2c_bit(input logic b, output logic r);
        m_sda_low <= !b;
        clk_n(8);
        scl <= 1'b1;
        clk_n(7);
        @(negedge clk_i) r = sda_line;
        @(posedge clk_i) scl <= 1'b0;
        clk_n(8);
    endtask

    task automatic i2c_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            i2c_bit(tx[i], r);
            rx[i] = r;
        end
        i2c_bit(1'b1, r);
        ack = !r;
    endtask

    task automatic i2c_start;
        m_sda_low <= 1'b0;
        clk_n(8);
        scl <= 1'b1;
        clk_n(8);
        m_sda_low <= 1'b1;
        clk_n(8);
        scl <= 1'b0;
        clk_n(8);
    endtask

    task automatic i2c_access(input logic [6:0] a, input logic wr, input logic [7:0] d,
                              input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        i2c_start();
        i2c_byte({a, 1'b0}, rx, ack);
        chk("addr_ack", ack, exp_ack);
        if (exp_ack)
        begin
            i2c_byte(8'h00, rx, ack);
            if (wr)
            begin
                i2c_byte(d, rx, ack);
                chk("data_ack", ack, 1'b1);
                i2c_byte(8'hA5, rx, ack);
                chk("extra_ack", ack, 1'b0);
            end
            else
            begin
                i2c_start();
                i2c_byte({a, 1'b1}, rx, ack);
                i2c_byte(8'hFF, rd, ack);
                chk("rdata", rd, d);
            end
        end
        m_sda_low <= 1'b1;
        clk_n(8);
        scl <= 1'b1;
        clk_n(8);
        m_sda_low <= 1'b0;
        clk_n(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_n(20);
        reset_n_i <= 1'b1;
        clk_n(4);
        phase(20);
        chk("sync_detect_out_live", sd_o, 1'b1);
        inv <= 1'b1;
        phase(10);
        pixels_per_clock_select <= 1'b1;
        phase(10);
        prog <= 1'b1;
        inv <= 1'b0;
        i2c_access(7'h76, 1'b1, 8'h03, 1'b1);
        exp_cfg = 8'h03;
        phase(10);
        dj <= 1'b1;
        phase(40);
        dj <= 1'b0;
        pixels_per_clock_select <= 1'b0;
        i2c_access(7'h75, 1'b1, 8'h00, 1'b0);
        phase(10);
        de_on <= 1'b0;
        repeat (70) @(posedge link_clk);
        chk("sync_detect_out_idle", sd_o, 1'b0);
        de_on <= 1'b1;
        repeat (8) @(posedge link_clk);
        chk("sync_detect_out_back", sd_o, 1'b1);
        run <= 1'b0;
        clk_n(300);
        chk("oe_noclk", oe_o, 1'b0);
        chk("sync_detect_out_noclk", sd_o, 1'b0);
        chk("even_noclk", even_o, 24'h000000);
        i2c_access(7'h76, 1'b0, 8'h03, 1'b1);
        power_down_n_i <= 1'b0;
        clk_n(10);
        chk("oe_pd", oe_o, 1'b0);
        power_down_n_i <= 1'b1;
        clk_n(10);
        i2c_access(7'h76, 1'b0, 8'h00, 1'b1);
        summarize();
    end

    initial
    begin
        clk_n(40000);
        error_cnt++;
        summarize();
    end
endmodule
